/* File: verilog/evh_pkg.sv */
// package for the extreme value hold judge
// assumes a single 40 MHz clock domain
package evh_pkg;

	// ---------------------------------------------------------------
	// widths and timing
	// ---------------------------------------------------------------
	localparam int MEAS_W          = 16;
	localparam int CLK_HZ          = 40000000;
	localparam int HOLD_TIME_MS    = 2000;
	localparam int HOLD_CYCLES     = CLK_HZ / 1000 * HOLD_TIME_MS;

	// ---------------------------------------------------------------
	// AHB-Lite register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_UPPER  = 8'h04;
	localparam logic [7:0] REG_LOWER  = 8'h08;
	localparam logic [7:0] REG_SLEVEL = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_HELD   = 8'h14;

	// ctrl field positions
	localparam int CTRL_MIN_BIT  = 0;
	localparam int CTRL_REAL_BIT = 1;
	localparam int CTRL_SELF_BIT = 2;
	localparam int CTRL_RST_BIT  = 3;
	localparam int CTRL_ERR_BIT  = 4;

	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [MEAS_W-1:0] UPPER_RESET = 16'hC000;
	localparam logic [MEAS_W-1:0] LOWER_RESET = 16'h4000;
	localparam logic [MEAS_W-1:0] LEVEL_RESET = 16'h2000;
	localparam logic [MEAS_W-1:0] MEAS_MAX    = 16'hFFFF;
	localparam logic [MEAS_W-1:0] MEAS_MIN    = 16'h0000;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef struct packed {
		logic go;
		logic high;
		logic low;
	} evh_judge_t;

	typedef struct packed {
		logic minMode;
		logic realUpd;
		logic selfTime;
	} evh_mode_t;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_RUN     = 2'b01,
		ST_SETTING = 2'b10
	} evh_state_t;

endpackage

/* File: verilog/evh_edge_det.sv */
// edge detector for one synchronous level
// assumes the input is already synchronous to mclk
`timescale 1ns/10ps
module evh_edge_det (
	// clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// level in, pulses out
	input  wire logic level,
	output logic      rise,
	output logic      fall
);
	logic prev_q;
	logic armed_q;

	// armed only once a real level has been seen after reset
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prev_q  <= 1'b0;
			armed_q <= 1'b0;
		end else begin
			prev_q  <= level;
			armed_q <= 1'b1;
		end
	end

	// one pulse per transition, none right after reset
	assign rise = armed_q & level & ~prev_q;  // [R18]
	assign fall = armed_q & ~level & prev_q;  // [R18]
endmodule

/* File: verilog/evh_judge.sv */
// threshold judge: exactly one of go, high, low
// assumes lower threshold not above upper
`timescale 1ns/10ps
module evh_judge
	import evh_pkg::*;
#(
	parameter int W = MEAS_W
) (
	// value and thresholds
	input  wire logic [W-1:0] value,
	input  wire logic [W-1:0] upper,
	input  wire logic [W-1:0] lower,
	// result
	output evh_pkg::evh_judge_t res
);
	initial begin
		if (W < 2) $error("evh_judge: width too small");
	end

	always_comb begin
		res = '0;
		if (value > upper) begin
			res.high = 1'b1;  // [R17]
		end else if (value < lower) begin
			res.low = 1'b1;  // [R17]
		end else begin
			res.go = 1'b1;  // [R17]
		end
	end
endmodule

/* File: verilog/evh_top.sv */
// extreme value hold judge with AHB-Lite register slave
// assumes inputs synchronous to mclk, single master, word transfers
// Operation
// [R1] self-timing real peak: hold until period
// [R2] rise above level: clear, track max
// [R3] fall below level: judge and freeze
// [R4] each new upward crossing restarts tracking
// [R5] min hold judges lowest value in period
// [R6] standby and outputs off until first result
// [R7] reset by input or button during error
// [R8] edge min: accumulate while timing low
// [R9] edge min: timing rise latches and judges
// [R10] real min: display follows running minimum
// [R11] real min: timing rise freezes result
// [R12] real min: timing fall resets minimum
// [R13] edge method updates only at boundary
// [R14] setting mode after two second hold
// [R15] edge peak: rise shows max, judges
// [R16] self edge peak: outputs off while capturing
// [R17] one judgement output from thresholds
// [R18] edges detected once, synchronously
`timescale 1ns/10ps
module evh_top
	import evh_pkg::*;
#(
	parameter int W           = MEAS_W,
	parameter int HOLD_CNT    = HOLD_CYCLES
) (
	// clock and reset
	input  wire logic              mclk,
	input  wire logic              nrst,
	// measurement and controller
	input  wire logic [W-1:0]      measValue,
	input  wire logic              timingIn,
	input  wire logic              extReset,
	input  wire logic              setButton,
	// judgement and display
	output evh_pkg::evh_judge_t    judgeOut,
	output logic [W-1:0]           dispValue,
	output logic                   standby,
	output logic                   settingMode,
	// AHB-Lite slave
	input  wire logic              hsel,
	input  wire logic [7:0]        haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic [31:0]            hrdata,
	output logic                   hreadyout,
	output logic                   hresp
);
	import evh_pkg::*;

	initial begin
		if (W != MEAS_W) $error("evh_top: width must match package");
		if (HOLD_CNT < 1) $error("evh_top: hold count below one");
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0]  ctrl_q;
	logic [W-1:0] upper_q, lower_q, level_q;
	logic         wrPend_q;
	logic [7:0]   wrAddr_q;
	evh_mode_t    mode;
	logic         errShown;
	logic         swReset;

	assign mode = {ctrl_q[CTRL_MIN_BIT], ctrl_q[CTRL_REAL_BIT],
		ctrl_q[CTRL_SELF_BIT]};
	assign errShown      = ctrl_q[CTRL_ERR_BIT];
	assign swReset  = wrPend_q && (wrAddr_q == REG_CTRL)
		&& hwdata[CTRL_RST_BIT];

	wire logic acc = hsel && hready && (htrans == HTRANS_NONSEQ);

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
		end else begin
			wrPend_q <= acc && hwrite;
			wrAddr_q <= haddr;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q  <= CTRL_RESET;
			upper_q <= UPPER_RESET;
			lower_q <= LOWER_RESET;
			level_q <= LEVEL_RESET;
		end else if (wrPend_q) begin
			case (wrAddr_q)
			REG_CTRL: begin
				ctrl_q <= hwdata & 32'h0000_0017;
			end
			REG_UPPER: begin
				upper_q <= hwdata[W-1:0];
			end
			REG_LOWER: begin
				lower_q <= hwdata[W-1:0];
			end
			REG_SLEVEL: begin
				level_q <= hwdata[W-1:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// reset sources
	// ---------------------------------------------------------------
	logic btnPrev_q;
	logic btnPress;
	logic softRst;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			btnPrev_q <= 1'b0;
		end else begin
			btnPrev_q <= setButton;
		end
	end
	assign btnPress = setButton & ~btnPrev_q;
	assign softRst  = extReset | swReset
		| (btnPress & errShown);  // [R7]

	// ---------------------------------------------------------------
	// setting mode after long press
	// ---------------------------------------------------------------
	logic [31:0] pressCnt_q;
	logic        setting_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pressCnt_q <= 32'h0000_0000;
			setting_q  <= 1'b0;
		end else if (!setButton) begin
			pressCnt_q <= 32'h0000_0000;
		end else if (!setting_q && !errShown) begin
			if (pressCnt_q >= 32'(HOLD_CNT - 1)) begin
				setting_q <= 1'b1;  // [R14]
			end else begin
				pressCnt_q <= pressCnt_q + 32'h0000_0001;
			end
		end else if (setting_q && btnPress) begin
			setting_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// period boundaries
	// ---------------------------------------------------------------
	logic tRise, tFall, above, aRise, aFall;
	logic start, stop;

	// self-timing: peak above level, bottom below level
	assign above = mode.minMode ? (measValue < level_q)
		: (measValue > level_q);

	evh_edge_det u_tim (
		.mclk (mclk),
		.nrst (nrst),
		.level(timingIn),
		.rise (tRise),
		.fall (tFall)
	);

	evh_edge_det u_lvl (
		.mclk (mclk),
		.nrst (nrst),
		.level(above),
		.rise (aRise),
		.fall (aFall)
	);

	// start opens a period, stop closes it
	assign start = mode.selfTime ? aRise : tFall;  // [R4] [R12]
	assign stop  = mode.selfTime ? aFall : tRise;  // [R3] [R9]

	// ---------------------------------------------------------------
	// extreme tracking
	// ---------------------------------------------------------------
	logic [W-1:0] ext_q, extNext, seed;
	logic         inPer_q;
	logic         better;

	assign seed   = mode.minMode ? MEAS_MAX : MEAS_MIN;
	assign better = mode.minMode ? (measValue < ext_q)
		: (measValue > ext_q);  // [R5]
	assign extNext = better ? measValue : ext_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			inPer_q <= 1'b0;
		end else if (softRst) begin
			inPer_q <= 1'b0;
		end else if (start) begin
			inPer_q <= 1'b1;
		end else if (stop) begin
			inPer_q <= 1'b0;
		end else if (!mode.selfTime && !timingIn) begin
			inPer_q <= 1'b1;  // [R8]
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ext_q <= MEAS_MIN;
		end else if (softRst) begin
			ext_q <= seed;
		end else if (start) begin
			ext_q <= measValue;  // [R2] [R4] [R12]
		end else if (inPer_q && !stop) begin
			ext_q <= extNext;  // [R8] [R15]
		end
	end

	// ---------------------------------------------------------------
	// judgement
	// ---------------------------------------------------------------
	evh_judge_t liveRes, heldRes;
	logic [W-1:0] judgeVal;

	assign judgeVal = stop ? extNext : ext_q;

	evh_judge #(.W(W)) u_judge (
		.value(judgeVal),
		.upper(upper_q),
		.lower(lower_q),
		.res  (liveRes)
	);
	assign heldRes = liveRes;

	// ---------------------------------------------------------------
	// display and outputs
	// ---------------------------------------------------------------
	evh_state_t state_q;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_q <= ST_STANDBY;
		end else if (softRst) begin
			state_q <= ST_STANDBY;  // [R6]
		end else begin
			case (state_q)
			ST_STANDBY: begin
				if (stop) begin
					state_q <= ST_RUN;
				end
			end
			ST_RUN: begin
				if (setting_q) begin
					state_q <= ST_SETTING;
				end
			end
			ST_SETTING: begin
				if (!setting_q) begin
					state_q <= ST_RUN;
				end
			end
			default: begin
				state_q <= ST_STANDBY;
			end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dispValue <= MEAS_MIN;
			judgeOut  <= '0;
		end else if (softRst) begin
			judgeOut  <= '0;  // [R6]
		end else if (stop) begin
			dispValue <= extNext;  // [R3] [R9] [R11] [R13] [R15]
			judgeOut  <= heldRes;  // [R9] [R15]
		end else if (state_q == ST_STANDBY) begin
			judgeOut  <= '0;  // [R6]
		end else if (inPer_q && mode.realUpd) begin
			dispValue <= extNext;  // [R2] [R10]
			judgeOut  <= heldRes;  // [R10]
		end else if (inPer_q && mode.selfTime) begin
			judgeOut  <= '0;  // [R16]
		end
		// outside a period all stay frozen  [R1] [R11]
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			standby     <= 1'b1;
			settingMode <= 1'b0;
		end else begin
			// standby drops with the first latched result
			standby     <= softRst
				|| (state_q == ST_STANDBY && !stop);  // [R6]
			settingMode <= setting_q;
		end
	end

	// ---------------------------------------------------------------
	// bus read
	// ---------------------------------------------------------------
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hrdata <= 32'h0000_0000;
		end else if (acc && !hwrite) begin
			case (haddr)
			REG_CTRL:   hrdata <= ctrl_q;
			REG_UPPER:  hrdata <= 32'(upper_q);
			REG_LOWER:  hrdata <= 32'(lower_q);
			REG_SLEVEL: hrdata <= 32'(level_q);
			REG_STATUS: hrdata <= {26'h0, inPer_q, setting_q,
				standby, judgeOut};
			REG_HELD:   hrdata <= 32'(dispValue);
			default:    hrdata <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end
endmodule

/* File: bench/evh_top_sva.sv */
// checker for the evh_top ports
// assumes thresholds are left at their reset values
`timescale 1ns/10ps
module evh_top_sva
	import evh_pkg::*;
#(
	parameter int W        = MEAS_W,
	parameter int HOLD_CNT = HOLD_CYCLES
) (
	// clock and reset
	input wire logic                mclk,
	input wire logic                nrst,
	// controller and result
	input wire logic                timingIn,
	input wire logic                extReset,
	input wire logic                setButton,
	input wire evh_pkg::evh_judge_t judgeOut,
	input wire logic [W-1:0]        dispValue,
	input wire logic                standby,
	input wire logic                settingMode,
	// bus
	input wire logic                hsel,
	input wire logic [7:0]          haddr,
	input wire logic [1:0]          htrans,
	input wire logic                hwrite,
	input wire logic [31:0]         hwdata,
	input wire logic                hready,
	input wire logic [31:0]         hrdata,
	input wire logic                hreadyout,
	input wire logic                hresp
);
	logic       tk;
	logic       wr_q;
	logic       rdBad_q;
	logic [7:0] adr_q;
	logic [4:0] ctrl_q;
	int         hold_q;
	assign tk = hsel && hready && htrans == HTRANS_NONSEQ;
	// shadow of ctrl bits 4:0 (mode, reset and error), from observed writes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			wr_q    <= 1'b0;
			rdBad_q <= 1'b0;
			adr_q   <= 8'h00;
		end else begin
			wr_q    <= tk && hwrite;
			rdBad_q <= tk && !hwrite && haddr > REG_HELD;
			adr_q   <= haddr;
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			ctrl_q <= 5'h00;
		else if (wr_q && adr_q == REG_CTRL)
			ctrl_q <= hwdata[4:0];
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			hold_q <= 0;
		else
			hold_q <= setButton ? hold_q + 1 : 0;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chk_one_judge: assert property ($onehot0(judgeOut))
		else $error("judge outputs not one-hot");
	chk_standby_dark: assert property (standby |-> judgeOut == 3'h0)
		else $error("output on during standby");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or error");
	chk_ext_clear: assert property (extReset |=> standby && !judgeOut)
		else $error("soft reset not applied");
	chk_err_button: assert property ($rose(setButton) && ctrl_q[4]
		|-> ##[1:3] standby) else $error("button reset ignored");
	chk_edge_frozen: assert property (ctrl_q[2:1] == 2'h0 &&
		$changed(dispValue) |-> $past(timingIn) || $past(timingIn, 2)
		|| $past(timingIn, 3)) else $error("display moved in period");
	chk_high_judge: assert property (judgeOut.high |->
		dispValue > UPPER_RESET || $past(dispValue) > UPPER_RESET)
		else $error("high without value above upper");
	chk_low_judge: assert property (judgeOut.low |->
		dispValue < LOWER_RESET || $past(dispValue) < LOWER_RESET)
		else $error("low without value below lower");
	chk_setting_hold: assert property ($rose(settingMode)
		|-> hold_q >= HOLD_CNT - 2) else $error("setting mode too early");
	chk_unmapped_zero: assert property (rdBad_q |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	cover property ($rose(settingMode));
	cover property ($fell(standby));
	cover property (judgeOut.low && !standby);
endmodule

bind evh_top evh_top_sva #(.W(W), .HOLD_CNT(HOLD_CNT)) sva (
	.mclk(mclk), .nrst(nrst), .timingIn(timingIn), .extReset(extReset),
	.setButton(setButton), .judgeOut(judgeOut), .dispValue(dispValue),
	.standby(standby), .settingMode(settingMode), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
);

/* File: bench/evh_ctrl_model.sv */
// controller model: timing input and soft reset line
// assumes callers run just after a rising edge of mclk
`timescale 1ns/10ps
module evh_ctrl_model (
	// clock
	input  wire logic mclk,
	// controller lines
	output logic      timingIn,
	output logic      extReset
);
	initial begin
		timingIn = 1'b1;
		extReset = 1'b0;
	end
	// low opens a period, rise closes it
	task automatic setTiming(input logic v);
		timingIn <= v;
	endtask
	task automatic pulseReset();
		extReset <= 1'b1;
		@(posedge mclk);
		extReset <= 1'b0;
	endtask
endmodule

/* File: bench/evh_top_bench.sv */
// self-checking bench for evh_top
// assumes thresholds stay at reset values until the final readback
`timescale 1ns/10ps
module evh_top_bench;
	import evh_pkg::*;
	localparam int HOLD = 20;
	localparam evh_judge_t GO = 3'h4, HI = 3'h2, LO = 3'h1, NO = 3'h0;
	logic mclk, nrst, timingIn, extReset, setButton, hsel, hwrite;
	logic standby, settingMode, hreadyout, hresp;
	logic [15:0] measValue, dispValue;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, rd;
	evh_judge_t judgeOut;
	int miscompares = 0;
	int totalChecks = 0;
	logic [7:0] ra [4] = '{REG_UPPER, REG_LOWER, REG_SLEVEL, 8'h3C};
	logic [15:0] rv [4] = '{16'hC000, 16'h4000, 16'h2000, 16'h0000};
	logic [15:0] pm [7] = '{16'h5000, 16'hD000, 16'h8000, 16'h1000,
		16'h1800, 16'h3000, 16'h1000};
	logic [15:0] pd [7] = '{16'h5000, 16'hD000, 16'hD000, 16'hD000,
		16'hD000, 16'h3000, 16'h3000};
	evh_judge_t pj [7] = '{GO, HI, HI, HI, HI, LO, LO};

	evh_top #(.HOLD_CNT(HOLD)) dut (
		.mclk(mclk), .nrst(nrst), .measValue(measValue),
		.timingIn(timingIn), .extReset(extReset), .setButton(setButton),
		.judgeOut(judgeOut), .dispValue(dispValue), .standby(standby),
		.settingMode(settingMode), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp)
	);
	evh_ctrl_model ctrl (.mclk(mclk), .timingIn(timingIn), .extReset(extReset));

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
			$display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
		if (got !== exp)
			miscompares++;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= HTRANS_NONSEQ;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic m(input logic [15:0] v, input int n);
		measValue <= v;
		tick(n);
	endtask
	task automatic see(input logic [15:0] d, input evh_judge_t j);
		cmp({16'h0000, dispValue}, {16'h0000, d});
		cmp({29'h0, judgeOut}, {29'h0, j});
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", totalChecks, miscompares);
		if (miscompares == 0 && totalChecks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		conclude();
	end

	initial begin
		nrst = 1'b0;
		setButton = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		measValue = 16'h8000;
		tick(20);
		nrst <= 1'b1;
		tick(1);
		see(16'h0000, NO);
		foreach (ra[i]) begin
			bus(ra[i], 1'b0, 32'h0);
			cmp(rd, {16'h0000, rv[i]});
		end
		// edge-triggered bottom hold
		bus(REG_CTRL, 1'b1, 32'h1);
		ctrl.setTiming(1'b0);
		m(16'h3000, 3);
		m(16'h9000, 3);
		see(16'h0000, NO);
		ctrl.setTiming(1'b1);
		tick(4);
		see(16'h3000, LO);
		cmp({31'h0, standby}, 32'h0);
		bus(REG_HELD, 1'b0, 32'h0);
		cmp(rd, 32'h3000);
		ctrl.setTiming(1'b0);
		m(16'h5000, 2);
		m(16'h7000, 3);
		see(16'h3000, LO);
		ctrl.setTiming(1'b1);
		tick(4);
		see(16'h5000, GO);
		// continuous bottom hold
		bus(REG_CTRL, 1'b1, 32'h3);
		m(16'hD000, 2);
		ctrl.setTiming(1'b0);
		tick(4);
		see(16'hD000, HI);
		m(16'h6000, 4);
		see(16'h6000, GO);
		m(16'h8000, 4);
		see(16'h6000, GO);
		ctrl.setTiming(1'b1);
		tick(3);
		m(16'h1000, 4);
		see(16'h6000, GO);
		m(16'hE000, 2);
		ctrl.setTiming(1'b0);
		tick(4);
		see(16'hE000, HI);
		// self-timing continuous peak hold
		m(16'h1000, 4);
		bus(REG_CTRL, 1'b1, 32'h6);
		foreach (pm[i]) begin
			m(pm[i], 4);
			see(pd[i], pj[i]);
		end
		// self-timing edge peak hold
		bus(REG_CTRL, 1'b1, 32'h4);
		m(16'h9000, 4);
		see(16'h3000, NO);
		m(16'h1000, 4);
		see(16'h9000, GO);
		// external edge peak hold
		bus(REG_CTRL, 1'b1, 32'h0);
		ctrl.setTiming(1'b1);
		tick(3);
		m(16'h4000, 2);
		ctrl.setTiming(1'b0);
		m(16'hB000, 3);
		m(16'h5000, 3);
		ctrl.setTiming(1'b1);
		tick(4);
		see(16'hB000, GO);
		// button reset while error shown, then controller reset
		bus(REG_CTRL, 1'b1, 32'h10);
		setButton <= 1'b1;
		tick(1);
		setButton <= 1'b0;
		tick(3);
		cmp({28'h0, standby, judgeOut}, 32'h8);
		bus(REG_CTRL, 1'b1, 32'h0);
		ctrl.setTiming(1'b0);
		tick(3);
		ctrl.setTiming(1'b1);
		tick(4);
		cmp({31'h0, standby}, 32'h0);
		ctrl.pulseReset();
		tick(2);
		cmp({28'h0, standby, judgeOut}, 32'h8);
		bus(REG_STATUS, 1'b0, 32'h0);
		cmp(rd, 32'h8);
		// software reset pulse through the control word
		ctrl.setTiming(1'b0);
		tick(3);
		ctrl.setTiming(1'b1);
		tick(4);
		cmp({31'h0, standby}, 32'h0);
		bus(REG_CTRL, 1'b1, 32'h8);
		tick(2);
		cmp({28'h0, standby, judgeOut}, 32'h8);
		// long press enters setting mode
		setButton <= 1'b1;
		tick(HOLD - 4);
		cmp({31'h0, settingMode}, 32'h0);
		tick(8);
		cmp({31'h0, settingMode}, 32'h1);
		setButton <= 1'b0;
		tick(2);
		// threshold write lands and reads back
		bus(REG_UPPER, 1'b1, 32'hF000);
		bus(REG_UPPER, 1'b0, 32'h0);
		cmp(rd, 32'hF000);
		conclude();
	end
endmodule
